//--- pkg/prs_defs.svh
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH
// Register indexes; byte address is index times four
`define PRS_IDX_PLL   8'h10
`define PRS_IDX_RLO   8'h11
`define PRS_IDX_RHI   8'h12
`define PRS_IDX_ACNT  8'h13
`define PRS_IDX_BLO   8'h14
`define PRS_IDX_BHI   8'h15
`define PRS_IDX_PRE   8'h16
`define PRS_IDX_ABL   8'h17
`define PRS_IDX_SYNC  8'h19
`define PRS_IDX_REFC  8'h1c
`define PRS_IDX_RSEL  8'h1d
`define PRS_IDX_CPI   8'h20
`define PRS_IDX_STAT  8'h21
// Reset values
`define PRS_RST_PD    2'h1
// Reference config bit positions
`define PRS_RC_SE1    0
`define PRS_RC_SE2    1
`define PRS_RC_DIFF   2
`define PRS_RC_STAY   3
`define PRS_RC_AUTO   4
`define PRS_RC_NODG   7
// Other bit positions
`define PRS_PRE_BBYP  3
`define PRS_PRE_RST   4
`define PRS_RS_SEC    0
`define PRS_RS_PIN    1
`define PRS_SY_LSB    6
// Edge counts for switchover
`define PRS_MISS_EDGES 2'h2
`define PRS_BACK_EDGES 3'h4
`endif

//--- pkg/prs_pkg.sv
package prs_pkg;
  // Charge pump modes
  typedef enum logic [2:0] {
    PRS_CP_HIZ  = 3'h0,
    PRS_CP_UP   = 3'h1,
    PRS_CP_DOWN = 3'h2,
    PRS_CP_NORM = 3'h3
  } prs_cp_e;
  // Prescaler modes
  typedef enum logic [2:0] {
    PRS_PM_DM2  = 3'h0,
    PRS_PM_DM4  = 3'h1,
    PRS_PM_DM8  = 3'h2,
    PRS_PM_DM16 = 3'h3,
    PRS_PM_DM32 = 3'h4,
    PRS_PM_FD1  = 3'h5,
    PRS_PM_FD2  = 3'h6,
    PRS_PM_FD3  = 3'h7
  } prs_pm_e;
  // Reference buffer power-downs
  typedef struct packed {
    logic diff;
    logic se1;
    logic se2;
  } prs_ref_pd_s;
  // Whole state of the block
  typedef struct packed {
    logic [1:0]  pd;
    prs_cp_e     cpm;
    logic [13:0] rdiv;
    logic [5:0]  acnt;
    logic [12:0] bcnt;
    prs_pm_e     pmode;
    logic        bbyp;
    logic        cnt_rst;
    logic [1:0]  abl;
    logic [1:0]  syncf;
    logic [7:0]  refc;
    logic [1:0]  rsel;
    logic [2:0]  cpi;
    logic        dph_wr;
    logic [7:0]  dph_idx;
    logic [31:0] hrdata;
    logic [1:0]  p_sy;
    logic [1:0]  s_sy;
    logic [1:0]  v_sy;
    logic [1:0]  pin_sy;
    logic [1:0]  syn_sy;
    logic        p_d;
    logic        s_d;
    logic        v_d;
    logic        mux_d;
    logic        sel_cur;
    logic        auto_sec;
    logic        missing;
    logic [1:0]  miss_cnt;
    logic [2:0]  back_cnt;
    logic [13:0] r_cnt;
    logic        r_out;
    logic [19:0] f_cnt;
    logic        f_out;
  } prs_state_s;
endpackage

//--- hw/prs_pll_ctrl.sv
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "prs_defs.svh"
`default_nettype none
module prs_pll_ctrl (
  // Clock, reset, enable
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Reference and oscillator pins
  input  wire logic                  primary_reference,
  input  wire logic                  secondary_reference,
  input  wire logic                  vco_clk_pin,
  input  wire logic                  ref_sel_pin,
  input  wire logic                  sync_n_pin,
  // Toward phase detector and charge pump
  output logic                       ref_div_out,
  output logic                       fb_div_out,
  output prs_pkg::prs_cp_e           charge_pump_ctrl,
  output logic      [2:0]            cp_current,
  output logic      [1:0]            abl_width,
  output prs_pkg::prs_ref_pd_s       ref_pd,
  output logic                       on_secondary
);
  // State and its next value
  prs_pkg::prs_state_s st_r;
  prs_pkg::prs_state_s st_nxt;
  // Edges seen on synchronised pins
  logic        p_rise;
  logic        p_any;
  logic        s_rise;
  logic        s_fall;
  logic        v_rise;
  // Control decodes
  logic        pll_pd;
  logic        diff_mode;
  logic        auto_mode;
  logic        want_sec;
  logic        new_rise;
  logic        sw_now;
  logic        ref_lvl;
  logic        ref_edge;
  logic        div_rst;
  logic        fixed_mode;
  logic [5:0]  pval;
  logic [12:0] b_eff;
  logic [5:0]  a_eff;
  logic [19:0] n_tot;
  logic [19:0] f_top;
  logic [13:0] r_top;
  logic        addr_ok;

  // Edge detect on second sync stage only
  assign p_rise = st_r.p_sy[1] & ~st_r.p_d;
  assign p_any  = st_r.p_sy[1] ^ st_r.p_d;
  assign s_rise = st_r.s_sy[1] & ~st_r.s_d;
  assign s_fall = ~st_r.s_sy[1] & st_r.s_d;
  assign v_rise = st_r.v_sy[1] & ~st_r.v_d;

  // Reference path decodes
  assign pll_pd    = st_r.pd != 2'h0;
  assign diff_mode = st_r.refc[`PRS_RC_DIFF];
  assign auto_mode = st_r.refc[`PRS_RC_AUTO] & ~diff_mode;

  // Wanted reference: auto tracker or manual select
  always_comb
  begin
    if (auto_mode)
      want_sec = st_r.auto_sec;
    else if (st_r.rsel[`PRS_RS_PIN])
      want_sec = st_r.pin_sy[1];
    else
      want_sec = st_r.rsel[`PRS_RS_SEC];
  end

  // Deglitch waits for the new input's rise; without it a
  // dead target would stall the switch, hence its off bit
  assign new_rise = want_sec ? s_rise : p_rise;
  assign sw_now   = (want_sec != st_r.sel_cur) &
                    (st_r.refc[`PRS_RC_NODG] | new_rise);

  // Muxed reference level, diff mode uses the primary pin
  assign ref_lvl  = (st_r.sel_cur & ~diff_mode) ? st_r.s_sy[1] : st_r.p_sy[1];
  // A switch at the new input's rise counts as one edge
  assign ref_edge = sw_now ? new_rise : (ref_lvl & ~st_r.mux_d);

  // Counter reset by bit or enabled sync pin
  assign div_rst = st_r.cnt_rst | ((st_r.syncf != 2'h0) & ~st_r.syn_sy[1]);

  // Reference divider terminal count, 0 and 1 divide by one
  assign r_top = (st_r.rdiv <= 14'h1) ? 14'h0 : 14'(st_r.rdiv - 14'h1);

  // Prescaler value and effective counts
  always_comb
  begin
    fixed_mode = 1'b0;
    pval       = 6'h2;
    unique case (st_r.pmode)
      prs_pkg::PRS_PM_DM2:  pval = 6'h2;
      prs_pkg::PRS_PM_DM4:  pval = 6'h4;
      prs_pkg::PRS_PM_DM8:  pval = 6'h8;
      prs_pkg::PRS_PM_DM16: pval = 6'h10;
      prs_pkg::PRS_PM_DM32: pval = 6'h20;
      prs_pkg::PRS_PM_FD1:
      begin
        pval       = 6'h1;
        fixed_mode = 1'b1;
      end
      prs_pkg::PRS_PM_FD2:
      begin
        pval       = 6'h2;
        fixed_mode = 1'b1;
      end
      prs_pkg::PRS_PM_FD3:
      begin
        pval       = 6'h3;
        fixed_mode = 1'b1;
      end
    endcase
    b_eff = (fixed_mode & st_r.bbyp) ? 13'h1 : st_r.bcnt;
    a_eff = fixed_mode ? 6'h0 : st_r.acnt;
    n_tot = 20'(20'(pval) * 20'(b_eff)) + 20'(a_eff);
    f_top = (n_tot == 20'h0) ? 20'h0 : 20'(n_tot - 20'h1);
  end

  // Register read mux
  function automatic logic [31:0] rd_val(
    input logic [7:0]          idx,
    input prs_pkg::prs_state_s s
  );
    logic [31:0] v;
    v = 32'h0;
    unique case (idx)
      `PRS_IDX_PLL:  v = {25'h0, s.cpm, 2'h0, s.pd};
      `PRS_IDX_RLO:  v = {24'h0, s.rdiv[7:0]};
      `PRS_IDX_RHI:  v = {26'h0, s.rdiv[13:8]};
      `PRS_IDX_ACNT: v = {26'h0, s.acnt};
      `PRS_IDX_BLO:  v = {24'h0, s.bcnt[7:0]};
      `PRS_IDX_BHI:  v = {27'h0, s.bcnt[12:8]};
      `PRS_IDX_PRE:  v = {27'h0, s.cnt_rst, s.bbyp, s.pmode};
      `PRS_IDX_ABL:  v = {30'h0, s.abl};
      `PRS_IDX_SYNC: v = {24'h0, s.syncf, 6'h0};
      `PRS_IDX_REFC: v = {24'h0, s.refc};
      `PRS_IDX_RSEL: v = {30'h0, s.rsel};
      `PRS_IDX_CPI:  v = {29'h0, s.cpi};
      `PRS_IDX_STAT: v = {29'h0, s.auto_sec, s.missing, s.sel_cur};
      default:       v = 32'h0;
    endcase
    return v;
  endfunction

  // Charge pump mode write decode, bad codes go high-Z
  function automatic prs_pkg::prs_cp_e cp_dec(input logic [2:0] c);
    prs_pkg::prs_cp_e m;
    m = prs_pkg::PRS_CP_HIZ;
    unique case (c)
      3'h1:    m = prs_pkg::PRS_CP_UP;
      3'h2:    m = prs_pkg::PRS_CP_DOWN;
      3'h3:    m = prs_pkg::PRS_CP_NORM;
      default: m = prs_pkg::PRS_CP_HIZ;
    endcase
    return m;
  endfunction

  // Address phase qualifier; zero wait states
  assign addr_ok = hsel & htrans[1] & hready;

  // Next-state logic for the whole block
  always_comb
  begin
    st_nxt = st_r;
    // Two-flop synchronisers, first stage feeds second only
    st_nxt.p_sy   = {st_r.p_sy[0], primary_reference};
    st_nxt.s_sy   = {st_r.s_sy[0], secondary_reference};
    st_nxt.v_sy   = {st_r.v_sy[0], vco_clk_pin};
    st_nxt.pin_sy = {st_r.pin_sy[0], ref_sel_pin};
    st_nxt.syn_sy = {st_r.syn_sy[0], sync_n_pin};
    st_nxt.p_d    = st_r.p_sy[1];
    st_nxt.s_d    = st_r.s_sy[1];
    st_nxt.v_d    = st_r.v_sy[1];
    st_nxt.mux_d  = ~sw_now ? ref_lvl : (want_sec & ~diff_mode) ? st_r.s_sy[1] : st_r.p_sy[1];
    // Bus address phase: latch write, prepare read data
    st_nxt.dph_wr  = addr_ok & hwrite;
    st_nxt.dph_idx = haddr[9:2];
    if (addr_ok & ~hwrite)
      st_nxt.hrdata = (haddr[31:10] == 22'h0) ? rd_val(haddr[9:2], st_r) : 32'h0;
    // Bus data phase: store the write
    if (st_r.dph_wr)
    begin
      unique case (st_r.dph_idx)
        `PRS_IDX_PLL:
        begin
          st_nxt.pd  = hwdata[1:0];
          st_nxt.cpm = cp_dec(hwdata[6:4]);
        end
        `PRS_IDX_RLO:  st_nxt.rdiv[7:0]  = hwdata[7:0];
        `PRS_IDX_RHI:  st_nxt.rdiv[13:8] = hwdata[5:0];
        `PRS_IDX_ACNT: st_nxt.acnt       = hwdata[5:0];
        `PRS_IDX_BLO:  st_nxt.bcnt[7:0]  = hwdata[7:0];
        `PRS_IDX_BHI:  st_nxt.bcnt[12:8] = hwdata[4:0];
        `PRS_IDX_PRE:
        begin
          st_nxt.pmode   = prs_pkg::prs_pm_e'(hwdata[2:0]);
          st_nxt.bbyp    = hwdata[`PRS_PRE_BBYP];
          st_nxt.cnt_rst = hwdata[`PRS_PRE_RST];
        end
        `PRS_IDX_ABL:  st_nxt.abl   = hwdata[1:0];
        `PRS_IDX_SYNC: st_nxt.syncf = hwdata[`PRS_SY_LSB+:2];
        `PRS_IDX_REFC: st_nxt.refc  = hwdata[7:0];
        `PRS_IDX_RSEL: st_nxt.rsel  = hwdata[1:0];
        `PRS_IDX_CPI:  st_nxt.cpi   = hwdata[2:0];
        default:       st_nxt.cpi   = st_r.cpi;
      endcase
    end
    // Primary watchdog clocked by secondary falls
    if (p_any)
      st_nxt.miss_cnt = 2'h0;
    else if (s_fall & (st_r.miss_cnt != `PRS_MISS_EDGES))
      st_nxt.miss_cnt = 2'(st_r.miss_cnt + 2'h1);
    // Two falls with no primary edge: missing, restart recovery
    if (~p_any & s_fall & (st_r.miss_cnt == 2'(`PRS_MISS_EDGES - 2'h1)))
    begin
      st_nxt.missing  = 1'b1;
      st_nxt.back_cnt = 3'h0;
      st_nxt.auto_sec = 1'b1;
    end
    else if (st_r.missing & p_rise)
    begin
      // Count primary rises toward recovery
      if (st_r.back_cnt == 3'(`PRS_BACK_EDGES - 3'h1))
      begin
        st_nxt.missing  = 1'b0;
        st_nxt.back_cnt = 3'h0;
        if (~st_r.refc[`PRS_RC_STAY])
          st_nxt.auto_sec = 1'b0;
      end
      else
        st_nxt.back_cnt = 3'(st_r.back_cnt + 3'h1);
    end
    // Leaving auto mode drops the tracker, so re-entry starts on primary
    if (~auto_mode)
      st_nxt.auto_sec = 1'b0;
    // Applied selection, at the new input's rise unless the deglitch off bit is set
    if (sw_now)
      st_nxt.sel_cur = want_sec;
    // Reference divider
    if (div_rst)
    begin
      st_nxt.r_cnt = 14'h0;
      st_nxt.r_out = 1'b0;
    end
    else if (ref_edge & (st_r.r_cnt >= r_top))
    begin
      st_nxt.r_cnt = 14'h0;
      st_nxt.r_out = 1'b1;
    end
    else
    begin
      st_nxt.r_cnt = ref_edge ? 14'(st_r.r_cnt + 14'h1) : st_r.r_cnt;
      st_nxt.r_out = 1'b0;
    end
    // Feedback divider, total count P*B+A
    if (div_rst)
    begin
      st_nxt.f_cnt = 20'h0;
      st_nxt.f_out = 1'b0;
    end
    else if (v_rise & (st_r.f_cnt >= f_top))
    begin
      st_nxt.f_cnt = 20'h0;
      st_nxt.f_out = 1'b1;
    end
    else
    begin
      st_nxt.f_cnt = v_rise ? 20'(st_r.f_cnt + 20'h1) : st_r.f_cnt;
      st_nxt.f_out = 1'b0;
    end
  end

  // State register; enable low freezes everything
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r    <= '0;
      st_r.pd <= `PRS_RST_PD;
    end
    else if (ce)
      st_r <= st_nxt;
  end

  // Outputs
  assign hrdata           = st_r.hrdata;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign ref_div_out      = st_r.r_out;
  assign fb_div_out       = st_r.f_out;
  assign charge_pump_ctrl = st_r.cpm;
  assign cp_current       = st_r.cpi;
  assign abl_width        = st_r.abl;
  assign on_secondary     = st_r.sel_cur;
  // Buffer power-downs
  assign ref_pd.diff = pll_pd | ~diff_mode;
  assign ref_pd.se1  = pll_pd | ~st_r.refc[`PRS_RC_SE1] | diff_mode;
  assign ref_pd.se2  = pll_pd | ~st_r.refc[`PRS_RC_SE2] | diff_mode;

  // Steps of a switchover
  sequence s_two_miss;
    ce && ~p_any && s_fall && st_r.miss_cnt == 2'h1;
  endsequence
  sequence s_sec_rise;
    ce && s_rise && auto_mode && st_r.missing && ~st_r.sel_cur;
  endsequence

  a_diff_pd: assert property (@(posedge hclk) disable iff (!hresetn)
    (pll_pd || !diff_mode) |-> ref_pd.diff)
    else $error("diff receiver not powered down");
  a_se_pd: assert property (@(posedge hclk) disable iff (!hresetn)
    (diff_mode || pll_pd) |-> (ref_pd.se1 && ref_pd.se2))
    else $error("single-ended buffer not powered down");
  a_refs_off: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(!hresetn) |-> (ref_pd.diff && ref_pd.se1 && ref_pd.se2))
    else $error("reference input on after reset");
  a_miss_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    s_two_miss |=> st_r.missing)
    else $error("primary not declared missing");
  a_go_secondary: assert property (@(posedge hclk) disable iff (!hresetn)
    s_sec_rise ##0 (auto_mode && st_r.auto_sec) |=> on_secondary)
    else $error("no handover to secondary");
  a_revert_primary: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st_r.missing && p_rise && ~s_fall && st_r.back_cnt == 3'h3
     && !st_r.refc[`PRS_RC_STAY]) |=> (!st_r.missing && !st_r.auto_sec))
    else $error("no revert after four primary rises");
  a_deglitch_sw: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !st_r.refc[`PRS_RC_NODG] && want_sec != st_r.sel_cur && !new_rise)
    |=> $stable(st_r.sel_cur))
    else $error("switch not on new reference rise");
  a_rdiv_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !div_rst && ref_edge && st_r.rdiv <= 14'h1) |=> ref_div_out)
    else $error("divide-by-one missed an edge");
  a_fb_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && v_rise && !div_rst && st_r.f_cnt == f_top) |=> (fb_div_out ##1 !fb_div_out))
    else $error("feedback terminal count wrong");
  a_sync_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st_r.syncf != 2'h0 && !st_r.syn_sy[1]) |=> (st_r.r_cnt == 14'h0 && st_r.f_cnt == 20'h0))
    else $error("sync reset did not clear counters");
  a_fixed_no_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fixed_mode |-> n_tot == 20'(20'(pval) * 20'(b_eff)))
    else $error("A counted in fixed mode");
endmodule
`default_nettype wire

//--- sim/prs_ref_src.sv
`timescale 1ns/1ps
`default_nettype none
module prs_ref_src #(
  parameter int P_HALF = 3,  // Primary half period in hclk cycles
  parameter int S_HALF = 5,  // Secondary half period in hclk cycles
  parameter int V_HALF = 2   // Oscillator half period in hclk cycles
) (
  // Clock and run controls
  input  wire logic hclk,
  input  wire logic p_run,
  input  wire logic s_run,
  input  wire logic sel_req,
  // Pins toward the block
  output logic      primary_reference,
  output logic      secondary_reference,
  output logic      vco_clk_pin,
  output logic      ref_sel_pin
);
  int pc;  // Primary phase counter
  int sc;  // Secondary phase counter
  int vc;  // Oscillator phase counter

  // Defined levels from time zero
  initial
  begin
    pc = 0;
    sc = 0;
    vc = 0;
    primary_reference = 1'b0;
    secondary_reference = 1'b0;
    vco_clk_pin = 1'b0;
    ref_sel_pin = 1'b0;
  end

  // Counters free-run; a stopped source holds its level like a dead CMOS driver
  // Each level lasts at least two hclk so the synchronisers see every edge
  always @(posedge hclk)
  begin
    pc <= (pc == P_HALF - 1) ? 0 : pc + 1;
    sc <= (sc == S_HALF - 1) ? 0 : sc + 1;
    vc <= (vc == V_HALF - 1) ? 0 : vc + 1;
    if (p_run && pc == P_HALF - 1)
      primary_reference <= ~primary_reference;
    if (s_run && sc == S_HALF - 1)
      secondary_reference <= ~secondary_reference;
    if (vc == V_HALF - 1)
      vco_clk_pin <= ~vco_clk_pin;
    ref_sel_pin <= sel_req;
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "prs_defs.svh"
module tb_top;
  // One table row: kind picks what is compared
  typedef struct {
    int          kind;
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [31:0] exp;
  } prs_row_s;
  logic                 hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
  logic [31:0]          haddr, hwdata, hrdata, got;
  logic [1:0]           htrans, abl_width;
  logic [2:0]           hsize, cp_current;
  logic                 primary_reference, secondary_reference, vco_clk_pin, ref_sel_pin, sync_n_pin;
  logic                 p_run, s_run, sel_req, ref_div_out, fb_div_out, on_secondary;
  prs_pkg::prs_cp_e     charge_pump_ctrl;
  prs_pkg::prs_ref_pd_s ref_pd;
  int                   n_mismatch = 0;
  int                   check_count = 0;
  // Kinds: 0 cp mode, 1 cp current, 2 backlash, 3 power-down, 4 readback, 5 R period, 6 N period
  // Reference period 6 cycles, oscillator period 4 cycles
  prs_row_s rows [0:34] = '{
    '{0, 8'h10, 32'h10, 32'h1}, '{0, 8'h10, 32'h20, 32'h2}, '{0, 8'h10, 32'h30, 32'h3},
    '{0, 8'h10, 32'h70, 32'h0}, '{0, 8'h10, 32'h00, 32'h0},
    '{1, 8'h20, 32'h0, 32'h0}, '{1, 8'h20, 32'h7, 32'h7}, '{1, 8'h20, 32'h5, 32'h5},
    '{2, 8'h17, 32'h3, 32'h3}, '{2, 8'h17, 32'h1, 32'h1},
    '{3, 8'h1c, 32'h03, 32'h4}, '{3, 8'h1c, 32'h01, 32'h5}, '{3, 8'h1c, 32'h04, 32'h3},
    '{3, 8'h1c, 32'h07, 32'h3}, '{3, 8'h10, 32'h01, 32'h7}, '{3, 8'h10, 32'h00, 32'h3},
    '{3, 8'h1c, 32'h03, 32'h4}, '{4, 8'h13, 32'h2a, 32'h2a}, '{4, 8'h18, 32'hff, 32'h0},
    '{4, 8'h21, 32'h07, 32'h0}, '{4, 8'h12, 32'hff, 32'h3f},
    '{5, 8'h0, 32'h0, 32'd6}, '{5, 8'h0, 32'h1, 32'd6}, '{5, 8'h0, 32'h5, 32'd30},
    '{5, 8'h0, 32'h100, 32'd1536},
    '{6, 8'h0, 32'h000003, 32'd24}, '{6, 8'h0, 32'h000103, 32'd28}, '{6, 8'h0, 32'h010103, 32'd52},
    '{6, 8'h0, 32'h020003, 32'd96}, '{6, 8'h0, 32'h030203, 32'd200}, '{6, 8'h0, 32'h040003, 32'd384},
    '{6, 8'h0, 32'h0d0509, 32'd4}, '{6, 8'h0, 32'h060303, 32'd24}, '{6, 8'h0, 32'h070004, 32'd48},
    '{6, 8'h0, 32'h080004, 32'd32}
  };

  prs_pll_ctrl u_prs_pll_ctrl (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .primary_reference(primary_reference),
    .secondary_reference(secondary_reference), .vco_clk_pin(vco_clk_pin), .ref_sel_pin(ref_sel_pin),
    .sync_n_pin(sync_n_pin), .ref_div_out(ref_div_out), .fb_div_out(fb_div_out),
    .charge_pump_ctrl(charge_pump_ctrl), .cp_current(cp_current), .abl_width(abl_width),
    .ref_pd(ref_pd), .on_secondary(on_secondary)
  );

  prs_ref_src u_prs_ref_src (
    .hclk(hclk), .p_run(p_run), .s_run(s_run), .sel_req(sel_req),
    .primary_reference(primary_reference), .secondary_reference(secondary_reference),
    .vco_clk_pin(vco_clk_pin), .ref_sel_pin(ref_sel_pin)
  );

  // 125 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Verdict and end of run
  task conclude;
    begin
      if (n_mismatch == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // A wait that ran out ends the run as a mismatch
  task give_up(input string what);
    begin
      n_mismatch++;
      $display("MISMATCH %s expected event, none seen", what);
      conclude();
    end
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
      check_count++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // Waits for hready high at a rising edge
  task wait_rdy;
    int k;
    begin
      k = 0;
      do
      begin
        @(posedge hclk);
        k++;
        if (k > 16)
          give_up("hready");
      end while (hreadyout !== 1'b1);
    end
  endtask

  // One single word transfer; read data taken at the closing edge
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    begin
      @(posedge hclk);
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      chk("hresp", 32'(hresp), 32'h0);
    end
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    begin
      bus(1'b1, idx, wd, d);
    end
  endtask

  // Cycles between divider pulses; the first two waits after a change are dropped, the third is kept
  task pulse_gap(input int sel, output logic [31:0] n);
    int k;
    logic hit;
    begin
      n = 0;
      for (int r = 0; r < 3; r++)
      begin
        k = 0;
        hit = 1'b0;
        while (!hit)
        begin
          @(posedge hclk);
          #1;
          k++;
          hit = ((sel == 0) ? ref_div_out : fb_div_out) === 1'b1;
          if (k > 3000)
            give_up("divider pulse");
        end
        n = k;
      end
    end
  endtask

  // High samples of either divider output over 200 cycles
  task pulses(output logic [31:0] n);
    begin
      n = 0;
      repeat (200)
      begin
        @(posedge hclk);
        #1;
        n = n + 32'(ref_div_out === 1'b1) + 32'(fb_div_out === 1'b1);
      end
    end
  endtask

  task wait_sec(input logic v);
    int k;
    begin
      k = 0;
      while (on_secondary !== v)
      begin
        @(posedge hclk);
        #1;
        k++;
        if (k > 400)
          give_up("on_secondary");
      end
    end
  endtask

  // Reset held 11 cycles; outputs checked while held, after the tenth
  task do_reset;
    begin
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      #1;
      chk("charge_pump_ctrl", 32'(charge_pump_ctrl), 32'h0);
      chk("ref_pd", 32'(ref_pd), 32'h7);
      chk("on_secondary", 32'(on_secondary), 32'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
    end
  endtask

  // Main sequence: table first, then hand-written cases
  initial
  begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sync_n_pin = 1'b1;
    p_run = 1'b1;
    s_run = 1'b1;
    sel_req = 1'b0;
    do_reset();
    for (int i = 0; i < 35; i++)
    begin
      if (rows[i].kind < 4)
        wr(rows[i].idx, rows[i].wd);
      if (rows[i].kind == 4)
      begin
        wr(rows[i].idx, rows[i].wd);
        bus(1'b0, rows[i].idx, 32'h0, got);
      end
      if (rows[i].kind == 5)
      begin
        wr(`PRS_IDX_RLO, {24'h0, rows[i].wd[7:0]});
        wr(`PRS_IDX_RHI, {26'h0, rows[i].wd[13:8]});
        pulse_gap(0, got);
      end
      if (rows[i].kind == 6)
      begin
        wr(`PRS_IDX_PRE, {24'h0, rows[i].wd[23:16]});
        wr(`PRS_IDX_ACNT, {24'h0, rows[i].wd[15:8]});
        wr(`PRS_IDX_BLO, {24'h0, rows[i].wd[7:0]});
        wr(`PRS_IDX_BHI, 32'h0);
        pulse_gap(1, got);
      end
      #1;
      case (rows[i].kind)
        0: got = 32'(charge_pump_ctrl);
        1: got = 32'(cp_current);
        2: got = 32'(abl_width);
        3: got = 32'(ref_pd);
        default: got = got;
      endcase
      chk("table row", got, rows[i].exp);
    end
    // Shared counter reset bit holds both dividers
    wr(`PRS_IDX_PRE, 32'h18);
    pulses(got);
    chk("counter reset", got, 32'h0);
    wr(`PRS_IDX_PRE, 32'h08);
    // Sync pin ignored until enabled, then holds the counters
    sync_n_pin <= 1'b0;
    pulses(got);
    chk("sync disabled", 32'(got != 32'h0), 32'h1);
    wr(`PRS_IDX_SYNC, 32'h40);
    pulses(got);
    chk("sync reset", got, 32'h0);
    // Enable low loses a bus write; counters stay held meanwhile
    @(posedge hclk);
    ce <= 1'b0;
    wr(`PRS_IDX_CPI, 32'h2);
    ce <= 1'b1;
    bus(1'b0, `PRS_IDX_CPI, 32'h0, got);
    chk("ce freeze", got, 32'h5);
    sync_n_pin <= 1'b1;
    // Manual select by register, then by pin, both sources running
    wr(`PRS_IDX_RSEL, 32'h1);
    wait_sec(1'b1);
    chk("reg select", 32'(on_secondary), 32'h1);
    wr(`PRS_IDX_RSEL, 32'h2);
    wait_sec(1'b0);
    sel_req <= 1'b1;
    wait_sec(1'b1);
    chk("pin select", 32'(on_secondary), 32'h1);
    wr(`PRS_IDX_RSEL, 32'h0);
    wait_sec(1'b0);
    // Prefer primary: lose it, then bring it back
    wr(`PRS_IDX_REFC, 32'h13);
    p_run <= 1'b0;
    wait_sec(1'b1);
    bus(1'b0, `PRS_IDX_STAT, 32'h0, got);
    chk("missing flag", 32'(got[1]), 32'h1);
    p_run <= 1'b1;
    wait_sec(1'b0);
    chk("revert", 32'(on_secondary), 32'h0);
    // Stay on secondary, then software brings primary back
    wr(`PRS_IDX_REFC, 32'h1b);
    p_run <= 1'b0;
    wait_sec(1'b1);
    p_run <= 1'b1;
    repeat (100) @(posedge hclk);
    #1;
    chk("stay", 32'(on_secondary), 32'h1);
    wr(`PRS_IDX_REFC, 32'h0b);
    wait_sec(1'b0);
    wr(`PRS_IDX_REFC, 32'h1b);
    repeat (50) @(posedge hclk);
    #1;
    chk("auto again", 32'(on_secondary), 32'h0);
    do_reset();
    conclude();
  end
endmodule
`default_nettype wire
